// ---- sgmap_core.sv ----
// Data memory segment mapper with program counter, pointers and accumulator datapath.
// Assumes instruction decode issues one request per port per cycle on clk_sys.
//
// What this block does
// - Output port drives all ones during reset.
// - Legacy input address reads the pin register.
// - Program counter is 15 bits, 7 plus 8.
// - Both RAM pointers post increment or decrement.
// - Segment register extends low half, 256x128.
// - Reset points stack pointer at 006F.
// - Every interrupt vectors to address 0FF.
// - Fetch starts at address zero after reset.
// - Erased program memory reads as 00.
// - Pointers mapped at 0FC, 0FD, 0FE.
// - Segment register lives at data address 0FF.
// - Upper half addresses bypass the segment.
// - Lower half uses segment as upper byte.
// - Stack accesses always use segment zero.
// - Base RAM at 0000-006F and 00F0-00FB only.
// - Extra RAM in segments 1 to 3.
// - Bit set, clear, test on memory; bit test only on accumulator.
// - ALU operations finish in one cycle.
// - Register file supports load and decrement-skip.
// - Accumulator and counter are not memory mapped.
// - Missing segments on small variant read as 00.
`timescale 1ns/100ps
module sgmap_core #(
  parameter int PM_SIZE  = 32768,
  parameter int RAM_SEGS = 4
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // Program counter control
  input  wire sgmap_pkg::sgmap_pc_t pc_op,
  input  wire logic [14:0]          pc_target,
  input  wire logic [7:0]           pm_rdata,
  // Data memory request
  input  wire logic                 dm_req,
  input  wire sgmap_pkg::sgmap_dop_t dm_op,
  input  wire sgmap_pkg::sgmap_mode_t dm_mode,
  input  wire sgmap_pkg::sgmap_adj_t dm_adj,
  input  wire logic [7:0]           dm_addr,
  input  wire logic [7:0]           dm_wdata,
  input  wire logic [2:0]           dm_bit,
  // Accumulator datapath
  input  wire logic                 alu_req,
  input  wire sgmap_pkg::sgmap_alu_t alu_op,
  input  wire logic [7:0]           alu_opnd,
  input  wire logic                 acc_test_req,
  input  wire logic [2:0]           acc_bit,
  // Pins
  input  wire logic [7:0]           port_pins_in,
  // Program side results
  output logic [6:0]                program_counter_high_q,
  output logic [7:0]                program_counter_low_q,
  output logic [7:0]                fetch_byte_q,
  // Data side results
  output logic                      dm_ack_q,
  output logic [7:0]                dm_rdata_q,
  output logic [15:0]               dm_eff_addr_q,
  output logic                      bit_zero_q,
  output logic                      skip_q,
  output logic [7:0]                acc_q,
  output logic                      carry_q,
  output logic                      acc_bit_q,
  output logic [7:0]                out_port_q
);
  import sgmap_pkg::*;

  initial begin
    if (PM_SIZE < 256 || PM_SIZE > 32768) $error("sgmap_core: PM_SIZE out of range");
  end

  // ***************************************************
  // Registers and pin synchroniser
  // ***************************************************
  logic [7:0] alt_ram_pointer_q;
  logic [7:0] stack_pointer_reg_q;
  logic [7:0] primary_ram_pointer_q;
  logic [7:0] segment_select_q;
  logic [7:0] pins_meta_q;
  logic [7:0] pins_sync_q;

  always_ff @(posedge clk_sys) begin
    pins_meta_q <= port_pins_in;
    pins_sync_q <= pins_meta_q;
  end

  // ***************************************************
  // Address selection
  // ***************************************************
  logic [7:0] ptr_val;
  always_comb begin
    ptr_val = dm_addr;
    unique case (dm_mode)
      SGMAP_MODE_DIRECT: ptr_val = dm_addr;
      SGMAP_MODE_PRI:    ptr_val = primary_ram_pointer_q;
      SGMAP_MODE_ALT:    ptr_val = alt_ram_pointer_q;
      SGMAP_MODE_STACK:  ptr_val = stack_pointer_reg_q;
      default:           ptr_val = dm_addr;
    endcase
  end

  wire        stack_ref = (dm_mode == SGMAP_MODE_STACK);
  wire [15:0] eff_addr;
  wire        ram_hit;
  wire [8:0]  ram_idx;
  wire [7:0]  ram_rdata;

  sgmap_xlate #(
    .RAM_SEGS (RAM_SEGS)
  ) u_xlate (
    .addr      (ptr_val),
    .stack_ref (stack_ref),
    .seg_sel   (segment_select_q),
    .eff_addr  (eff_addr),
    .ram_hit   (ram_hit),
    .ram_idx   (ram_idx)
  );

  // ***************************************************
  // Location decode and read value
  // ***************************************************
  wire base_loc   = (eff_addr[15:8] == BYTE_ZERO);
  wire hit_alt    = base_loc && (ptr_val == ALT_PTR_ADDR);
  wire hit_stack  = base_loc && (ptr_val == STACK_PTR_ADDR);
  wire hit_pri    = base_loc && (ptr_val == PRI_PTR_ADDR);
  wire hit_seg    = base_loc && (ptr_val == SEG_SEL_ADDR);
  wire hit_pins   = base_loc && ((ptr_val == PORT_PIN_ADDR) || (ptr_val == LEGACY_IN_ADDR));
  wire hit_oport  = base_loc && (ptr_val == OUT_PORT_ADDR);
  wire hit_reg    = hit_alt | hit_stack | hit_pri | hit_seg;
  wire hit_ram    = ram_hit && !hit_reg;

  // Unmapped or missing locations read as zero rather than floating
  wire [7:0] old_val = hit_alt   ? alt_ram_pointer_q     :
                       hit_stack ? stack_pointer_reg_q   :
                       hit_pri   ? primary_ram_pointer_q :
                       hit_seg   ? segment_select_q      :
                       hit_pins  ? pins_sync_q           :
                       hit_oport ? out_port_q            :
                       hit_ram   ? ram_rdata             : BYTE_ZERO;

  // ***************************************************
  // Read-modify-write of one location
  // ***************************************************
  wire [7:0] bit_mask = 8'h01 << dm_bit;
  wire [7:0] dec_val  = old_val - 8'h01;
  logic [7:0] new_val;
  logic       do_write;
  always_comb begin
    new_val  = old_val;
    do_write = 1'b0;
    unique case (dm_op)
      SGMAP_DOP_READ:  begin
        do_write = 1'b0;
      end
      SGMAP_DOP_WRITE: begin
        new_val  = dm_wdata;
        do_write = 1'b1;
      end
      SGMAP_DOP_BSET:  begin
        new_val  = old_val | bit_mask;
        do_write = 1'b1;
      end
      SGMAP_DOP_BCLR:  begin
        new_val  = old_val & ~bit_mask;
        do_write = 1'b1;
      end
      SGMAP_DOP_BTEST: begin
        do_write = 1'b0;
      end
      SGMAP_DOP_DSKIP: begin
        new_val  = dec_val;
        do_write = 1'b1;
      end
      default: begin
        do_write = 1'b0;
      end
    endcase
  end

  wire wr_go = dm_req && do_write;
  // Pins are input only; a write there is dropped
  wire ram_we = wr_go && hit_ram;

  sgmap_ram #(
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .clk_sys (clk_sys),
    .wr_en   (ram_we),
    .idx     (ram_idx),
    .wr_data (new_val),
    .rd_data (ram_rdata)
  );

  // ***************************************************
  // Pointer post adjust
  // ***************************************************
  // Adjust acts on the pointer that addressed this access; the old value has already been used
  wire adj_go  = dm_req && (dm_adj != SGMAP_ADJ_NONE);
  wire adj_inc = (dm_adj == SGMAP_ADJ_INC);
  wire [7:0] ptr_adj = adj_inc ? ptr_val + 8'h01 : ptr_val - 8'h01;

  wire adj_pri   = adj_go && (dm_mode == SGMAP_MODE_PRI);
  wire adj_alt   = adj_go && (dm_mode == SGMAP_MODE_ALT);
  wire adj_stack = adj_go && (dm_mode == SGMAP_MODE_STACK);

  // A data write to a pointer's own location wins over its adjust
  wire [7:0] pri_d   = (wr_go && hit_pri)   ? new_val : adj_pri   ? ptr_adj : primary_ram_pointer_q;
  wire [7:0] alt_d   = (wr_go && hit_alt)   ? new_val : adj_alt   ? ptr_adj : alt_ram_pointer_q;
  wire [7:0] stack_d = (wr_go && hit_stack) ? new_val : adj_stack ? ptr_adj : stack_pointer_reg_q;
  wire [7:0] seg_d   = (wr_go && hit_seg)   ? new_val : segment_select_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      primary_ram_pointer_q <= PTR_RST;
      alt_ram_pointer_q     <= PTR_RST;
      stack_pointer_reg_q   <= STACK_PTR_RST;
      segment_select_q      <= SEG_SEL_RST;
    end else begin
      primary_ram_pointer_q <= pri_d;
      alt_ram_pointer_q     <= alt_d;
      stack_pointer_reg_q   <= stack_d;
      segment_select_q      <= seg_d;
    end
  end

  // ***************************************************
  // Output port
  // ***************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      out_port_q <= OUT_PORT_RST;
    end else if (wr_go && hit_oport) begin
      out_port_q <= new_val;
    end
  end

  // ***************************************************
  // Data answer
  // ***************************************************
  wire test_op = (dm_op == SGMAP_DOP_BTEST);
  wire skip_op = (dm_op == SGMAP_DOP_DSKIP);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dm_ack_q      <= 1'b0;
      dm_rdata_q    <= BYTE_ZERO;
      dm_eff_addr_q <= 16'h0000;
      bit_zero_q    <= 1'b0;
      skip_q        <= 1'b0;
    end else begin
      dm_ack_q <= dm_req;
      if (dm_req) begin
        dm_rdata_q    <= old_val;
        dm_eff_addr_q <= eff_addr;
        bit_zero_q    <= test_op && ((old_val & bit_mask) == BYTE_ZERO);
        skip_q        <= skip_op && (dec_val == BYTE_ZERO);
      end
    end
  end

  // ***************************************************
  // Accumulator, kept out of the data map
  // ***************************************************
  logic [8:0] alu_res;
  always_comb begin
    alu_res = {carry_q, acc_q};
    unique case (alu_op)
      SGMAP_ALU_ADD: alu_res = {1'b0, acc_q} + {1'b0, alu_opnd};
      SGMAP_ALU_SUB: alu_res = {1'b0, acc_q} - {1'b0, alu_opnd};
      SGMAP_ALU_AND: alu_res = {carry_q, acc_q & alu_opnd};
      SGMAP_ALU_OR:  alu_res = {carry_q, acc_q | alu_opnd};
      SGMAP_ALU_XOR: alu_res = {carry_q, acc_q ^ alu_opnd};
      SGMAP_ALU_SHL: alu_res = {acc_q, 1'b0};
      SGMAP_ALU_SHR: alu_res = {acc_q[0], 1'b0, acc_q[7:1]};
      SGMAP_ALU_LD:  alu_res = {carry_q, alu_opnd};
      default:       alu_res = {carry_q, acc_q};
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc_q     <= BYTE_ZERO;
      carry_q   <= 1'b0;
      acc_bit_q <= 1'b0;
    end else begin
      if (alu_req) begin
        acc_q   <= alu_res[7:0];
        carry_q <= alu_res[8];
      end
      if (acc_test_req) begin
        acc_bit_q <= acc_q[acc_bit];
      end
    end
  end

  // ***************************************************
  // Program counter and fetch
  // ***************************************************
  wire [14:0] pc_now  = {program_counter_high_q, program_counter_low_q};
  logic [14:0] pc_d;
  always_comb begin
    pc_d = pc_now;
    unique case (pc_op)
      SGMAP_PC_HOLD: pc_d = pc_now;
      SGMAP_PC_STEP: pc_d = pc_now + 15'h0001;
      SGMAP_PC_JUMP: pc_d = pc_target;
      SGMAP_PC_VEC:  pc_d = INTR_VECTOR;
      default:       pc_d = pc_now;
    endcase
  end

  // Beyond the fitted program memory the array is treated as erased
  wire pm_fitted = ({17'h00000, pc_now} < PM_SIZE);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      program_counter_high_q <= PC_RST[14:8];
      program_counter_low_q  <= PC_RST[7:0];
      fetch_byte_q           <= ERASED_BYTE;
    end else begin
      program_counter_high_q <= pc_d[14:8];
      program_counter_low_q  <= pc_d[7:0];
      fetch_byte_q           <= pm_fitted ? pm_rdata : ERASED_BYTE;
    end
  end

endmodule

// ---- sgmap_core_monitor.sv ----
// Port checker for the segment mapper top.
// Assumes binding into sgmap_core; single clock, sync reset.
`timescale 1ns/100ps
module sgmap_core_monitor #(
  parameter int PM_SIZE = 32768
) (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst_b,
  // Requests
  input wire sgmap_pkg::sgmap_pc_t   pc_op,
  input wire logic                   dm_req,
  input wire sgmap_pkg::sgmap_mode_t dm_mode,
  input wire logic [7:0]             dm_addr,
  input wire logic                   alu_req,
  input wire sgmap_pkg::sgmap_alu_t  alu_op,
  input wire logic [7:0]             alu_opnd,
  // Results
  input wire logic [6:0]             program_counter_high_q,
  input wire logic [7:0]             program_counter_low_q,
  input wire logic [7:0]             fetch_byte_q,
  input wire logic [15:0]            dm_eff_addr_q,
  input wire logic [7:0]             acc_q,
  input wire logic [7:0]             out_port_q
);
  import sgmap_pkg::*;
  wire [14:0] pc = {program_counter_high_q, program_counter_low_q};
  // ****************
  // Properties
  // ****************
  // Reset checks carry no disable: they are about reset itself
  property p_rst_port;
    @(posedge clk_sys) !rst_b |=> out_port_q == 8'hff;
  endproperty
  a_rst_port: assert property (p_rst_port) else $error("output port not high in reset");
  property p_rst_pc;
    @(posedge clk_sys) !rst_b |=> pc == 15'h0000;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("counter not zero after reset");
  property p_pc_step;
    @(posedge clk_sys) disable iff (!rst_b) pc_op == SGMAP_PC_STEP |=> pc == $past(pc) + 15'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter step wrong");
  property p_vec;
    @(posedge clk_sys) disable iff (!rst_b) pc_op == SGMAP_PC_VEC |=> pc == 15'h00ff;
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_erased;
    @(posedge clk_sys) disable iff (!rst_b) int'(pc) >= PM_SIZE |=> fetch_byte_q == 8'h00;
  endproperty
  a_erased: assert property (p_erased) else $error("erased fetch not 00");
  property p_upper;
    @(posedge clk_sys) disable iff (!rst_b)
      dm_req && dm_mode == SGMAP_MODE_DIRECT && dm_addr[7] |=> dm_eff_addr_q == {8'h00, $past(dm_addr)};
  endproperty
  a_upper: assert property (p_upper) else $error("upper half address extended");
  property p_lower;
    @(posedge clk_sys) disable iff (!rst_b)
      dm_req && dm_mode == SGMAP_MODE_DIRECT && !dm_addr[7] |=> dm_eff_addr_q[7:0] == ($past(dm_addr) & 8'h7f);
  endproperty
  a_lower: assert property (p_lower) else $error("lower half offset wrong");
  property p_stack;
    @(posedge clk_sys) disable iff (!rst_b) dm_req && dm_mode == SGMAP_MODE_STACK |=> dm_eff_addr_q[15:8] == 8'h00;
  endproperty
  a_stack: assert property (p_stack) else $error("stack access left segment zero");
  property p_alu;
    @(posedge clk_sys) disable iff (!rst_b) alu_req && alu_op == SGMAP_ALU_LD |=> acc_q == $past(alu_opnd);
  endproperty
  a_alu: assert property (p_alu) else $error("accumulator load late or wrong");
  c_vec: cover property (@(posedge clk_sys) disable iff (!rst_b) pc_op == SGMAP_PC_VEC);
  c_stack: cover property (@(posedge clk_sys) disable iff (!rst_b) dm_req && dm_mode == SGMAP_MODE_STACK);
  c_erased: cover property (@(posedge clk_sys) disable iff (!rst_b) int'(pc) >= PM_SIZE);
endmodule

bind sgmap_core sgmap_core_monitor #(.PM_SIZE(PM_SIZE)) sgmap_core_monitor_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .pc_op(pc_op), .dm_req(dm_req), .dm_mode(dm_mode),
  .dm_addr(dm_addr), .alu_req(alu_req), .alu_op(alu_op), .alu_opnd(alu_opnd),
  .program_counter_high_q(program_counter_high_q), .program_counter_low_q(program_counter_low_q),
  .fetch_byte_q(fetch_byte_q), .dm_eff_addr_q(dm_eff_addr_q), .acc_q(acc_q), .out_port_q(out_port_q));

// ---- sgmap_core_tb.sv ----
// Random traffic bench for the mapper against a reference model.
// Assumes the program memory model feeds pm_rdata.
`timescale 1ns/100ps
module sgmap_core_tb;
  import sgmap_pkg::*;
  typedef struct packed {
    logic ack, kk, bz, sk, cyk, cy, abk, ab;
    logic [7:0] rd, acc, fb, out;
    logic [15:0] ea;
    logic [14:0] pc;
  } sgmap_exp_t;
  localparam int PMS = 256;
  localparam int RS  = 4;
  logic        clk_sys = 1'b0, rst_b = 1'b0, dm_req = 1'b0, alu_req = 1'b0, acc_test_req = 1'b0;
  sgmap_pc_t   pc_op   = SGMAP_PC_HOLD;
  sgmap_dop_t  dm_op   = SGMAP_DOP_READ;
  sgmap_mode_t dm_mode = SGMAP_MODE_DIRECT;
  sgmap_adj_t  dm_adj  = SGMAP_ADJ_NONE;
  sgmap_alu_t  alu_op  = SGMAP_ALU_LD;
  logic [14:0] pc_target = 15'h0000;
  logic [7:0]  dm_addr = 8'h00, dm_wdata = 8'h00, alu_opnd = 8'h00, port_pins_in = 8'h00, pm_rdata;
  logic [2:0]  dm_bit = 3'h0, acc_bit = 3'h0;
  logic [6:0]  pch;
  logic [7:0]  pcl, fb, rd, acc, outp, rx, rsp, rb, rseg, rout, racc;
  logic        ack, bz, sk, cy, ab, rcy;
  logic [15:0] ea;
  logic [14:0] rpc;
  logic [7:0]  m [int];
  sgmap_exp_t  e, nx;
  integer      seed = 32'h0180;
  int          n_errors = 0, n_compared = 0, cyc = 0;

  sgmap_core #(.PM_SIZE(PMS), .RAM_SEGS(RS)) sgmap_core_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .pc_op(pc_op), .pc_target(pc_target), .pm_rdata(pm_rdata),
    .dm_req(dm_req), .dm_op(dm_op), .dm_mode(dm_mode), .dm_adj(dm_adj), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_bit(dm_bit), .alu_req(alu_req), .alu_op(alu_op), .alu_opnd(alu_opnd),
    .acc_test_req(acc_test_req), .acc_bit(acc_bit), .port_pins_in(port_pins_in),
    .program_counter_high_q(pch), .program_counter_low_q(pcl), .fetch_byte_q(fb), .dm_ack_q(ack),
    .dm_rdata_q(rd), .dm_eff_addr_q(ea), .bit_zero_q(bz), .skip_q(sk), .acc_q(acc), .carry_q(cy),
    .acc_bit_q(ab), .out_port_q(outp));
  sgmap_pm_model sgmap_pm_model_inst (
    .program_counter_high_q(pch), .program_counter_low_q(pcl), .pm_rdata(pm_rdata));

  always #2 clk_sys = ~clk_sys;
  // Two rounds of about 620 cycles each
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ****************
  // Reference model
  // ****************
  function automatic logic ram(input logic [15:0] a);
    return a[15:8] == 8'h00 ? (a[7:0] <= 8'h6f || (a[7:0] >= 8'hf0 && a[7:0] <= 8'hfb))
                            : (a[15:8] < RS && !a[7]);
  endfunction
  task automatic rdm(input logic [15:0] a, output logic [7:0] v, output logic k);
    k = 1'b1;
    v = 8'h00;
    if (a == 16'h00fc) v = rx;
    else if (a == 16'h00fd) v = rsp;
    else if (a == 16'h00fe) v = rb;
    else if (a == 16'h00ff) v = rseg;
    else if (a == 16'h00dc) v = rout;
    else if (a == 16'h0096 || a == 16'h00d7) v = port_pins_in;
    else if (ram(a)) begin
      k = m.exists(a);
      if (k) v = m[a];
    end
  endtask
  task automatic wrm(input logic [15:0] a, input logic [7:0] v, input logic k);
    if (a == 16'h00fc) rx = v;
    else if (a == 16'h00fd) rsp = v;
    else if (a == 16'h00fe) rb = v;
    else if (a == 16'h00ff) rseg = v;
    else if (a == 16'h00dc) rout = v;
    else if (ram(a) && k) m[a] = v;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // ****************
  // Stimulus
  // ****************
  task automatic step(input int i);
    int op, md, aj, ao, po;
    logic [7:0] a, p, o, n, v, d, l;
    logic [2:0] b;
    logic [15:0] x;
    logic [14:0] t;
    logic k, rq, aq, tq, w;
    e = nx;
    op = {$random(seed)} % 6;
    md = {$random(seed)} % 4;
    aj = {$random(seed)} % 3;
    ao = {$random(seed)} % 8;
    po = {$random(seed)} % 4;
    a = $random(seed);
    v = $random(seed);
    d = $random(seed);
    b = $random(seed);
    t = 15'($random(seed)) & 15'h01ff;
    rq = ($random(seed) & 3) != 0;
    aq = $random(seed);
    tq = !aq && ($random(seed) & 1);
    // Crowd addresses so RAM rereads, register file and segments get hit
    if (i % 3 == 1) a = a | 8'hf0;
    if (i % 3 == 2) a = a & 8'h07;
    if (i % 16 == 4) begin
      rq = 1'b1;
      md = 0;
      op = 1;
      a = 8'hff;
    end
    if (i % 16 == 5) begin
      rq = 1'b1;
      md = 0;
      a = (i % 32 == 5) ? 8'h96 : 8'hd7;
    end
    if (i < 4) begin
      rq = 1'b1;
      op = 0;
      md = 0;
      a = 8'hfc + 8'(i);
    end
    nx.fb = rpc < PMS ? rpc[7:0] ^ {1'b1, rpc[14:8]} : 8'h00;
    rpc = po == 1 ? rpc + 15'h0001 : po == 2 ? t : po == 3 ? 15'h00ff : rpc;
    nx.pc = rpc;
    nx.ack = rq;
    if (rq) begin
      p = md == 1 ? rb : md == 2 ? rx : md == 3 ? rsp : a;
      x = (p[7] || md == 3) ? {8'h00, p} : {rseg, 1'b0, p[6:0]};
      rdm(x, o, k);
      if (op == 1 && x == 16'h00ff) v = v & 8'h07;
      n = op == 1 ? v : op == 2 ? o | (8'h01 << b) : op == 3 ? o & ~(8'h01 << b) : o - 8'h01;
      w = op != 0 && op != 4;
      if (w) wrm(x, n, k || op == 1);
      l = md == 1 ? 8'hfe : md == 2 ? 8'hfc : 8'hfd;
      if (aj != 0 && md != 0 && !(w && x == {8'h00, l})) begin
        p = aj == 1 ? 8'h01 : 8'hff;
        if (md == 1) rb = rb + p;
        else if (md == 2) rx = rx + p;
        else rsp = rsp + p;
      end
      nx.rd = o;
      nx.kk = k;
      nx.ea = x;
      nx.bz = op == 4 && !o[b];
      nx.sk = op == 5 && n == 8'h00;
    end
    nx.out = rout;
    nx.abk = nx.abk || tq;
    if (tq) nx.ab = racc[b];
    if (aq) begin
      nx.cyk = ao < 2 || ao == 5 || ao == 6;
      if (ao == 0) {rcy, racc} = {1'b0, racc} + {1'b0, d};
      else if (ao == 1) {rcy, racc} = {1'b0, racc} - {1'b0, d};
      else if (ao == 2) racc = racc & d;
      else if (ao == 3) racc = racc | d;
      else if (ao == 4) racc = racc ^ d;
      else if (ao == 5) {rcy, racc} = {racc, 1'b0};
      else if (ao == 6) {racc, rcy} = {1'b0, racc};
      else racc = d;
      nx.acc = racc;
      nx.cy = rcy;
    end
    pc_op <= sgmap_pc_t'(4'h1 << po);
    pc_target <= t;
    dm_req <= rq;
    dm_op <= sgmap_dop_t'(6'h01 << op);
    dm_mode <= sgmap_mode_t'(4'h1 << md);
    dm_adj <= sgmap_adj_t'(3'h1 << aj);
    dm_addr <= a;
    dm_wdata <= v;
    dm_bit <= b;
    alu_req <= aq;
    alu_op <= sgmap_alu_t'(8'h01 << ao);
    alu_opnd <= d;
    acc_test_req <= tq;
    acc_bit <= b;
  endtask
  task automatic cmp();
    chk(ack, e.ack);
    chk(ea, e.ea);
    if (e.kk) chk(rd, e.rd);
    if (e.kk) chk({bz, sk}, {e.bz, e.sk});
    chk(acc, e.acc);
    if (e.cyk) chk(cy, e.cy);
    if (e.abk) chk(ab, e.ab);
    chk({pch, pcl}, e.pc);
    chk(fb, e.fb);
    chk(outp, e.out);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    dm_req <= 1'b0;
    alu_req <= 1'b0;
    acc_test_req <= 1'b0;
    pc_op <= SGMAP_PC_HOLD;
    port_pins_in <= $random(seed);
    repeat (19) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(outp, 8'hff);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    {rx, rb, rseg, racc, rcy, rpc} = '0;
    rsp = 8'h6f;
    rout = 8'hff;
    nx = '0;
    nx.kk = 1'b1;
    nx.cyk = 1'b1;
    nx.abk = 1'b1;
    nx.out = 8'hff;
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Second round repeats reset in mid-run, RAM kept
  initial begin
    for (int r = 0; r < 2; r++) begin
      do_reset();
      for (int i = 0; i < 600; i++) begin
        step(i);
        @(negedge clk_sys);
        cmp();
        @(posedge clk_sys);
      end
    end
    end_of_test();
  end
endmodule

// ---- sgmap_pkg.sv ----
// Constants, field layouts and operation codes of the segment mapper.
// Assumes a single core clock; shared by the mapper top and its leaves.
package sgmap_pkg;

  // ***************************************************
  // Data memory locations in the base segment
  // ***************************************************
  localparam logic [7:0]  ALT_PTR_ADDR     = 8'hfc;
  localparam logic [7:0]  STACK_PTR_ADDR   = 8'hfd;
  localparam logic [7:0]  PRI_PTR_ADDR     = 8'hfe;
  localparam logic [7:0]  SEG_SEL_ADDR     = 8'hff;
  localparam logic [3:0]  REG_FILE_HI      = 4'hf;
  localparam logic [7:0]  LEGACY_IN_ADDR   = 8'hd7;
  localparam logic [7:0]  PORT_PIN_ADDR    = 8'h96;
  localparam logic [7:0]  OUT_PORT_ADDR    = 8'hdc;
  localparam logic [6:0]  LOW_RAM_TOP      = 7'h6f;

  // ***************************************************
  // Values after reset and fixed vectors
  // ***************************************************
  localparam logic [7:0]  STACK_PTR_RST    = 8'h6f;
  localparam logic [7:0]  PTR_RST          = 8'h00;
  localparam logic [7:0]  SEG_SEL_RST      = 8'h00;
  localparam logic [7:0]  OUT_PORT_RST     = 8'hff;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [7:0]  ERASED_BYTE      = 8'h00;
  localparam logic [14:0] PC_RST           = 15'h0000;
  localparam logic [14:0] INTR_VECTOR      = 15'h00ff;
  localparam int          PCH_W            = 7;
  localparam int          PCL_W            = 8;
  localparam int          RAM_DEPTH        = 512;

  // ***************************************************
  // Operation codes
  // ***************************************************
  typedef enum logic [3:0] {
    SGMAP_MODE_DIRECT = 4'b0001, SGMAP_MODE_PRI = 4'b0010,
    SGMAP_MODE_ALT    = 4'b0100, SGMAP_MODE_STACK = 4'b1000
  } sgmap_mode_t;
  typedef enum logic [2:0] {
    SGMAP_ADJ_NONE = 3'b001, SGMAP_ADJ_INC = 3'b010, SGMAP_ADJ_DEC = 3'b100
  } sgmap_adj_t;
  typedef enum logic [5:0] {
    SGMAP_DOP_READ = 6'b000001, SGMAP_DOP_WRITE = 6'b000010, SGMAP_DOP_BSET = 6'b000100,
    SGMAP_DOP_BCLR = 6'b001000, SGMAP_DOP_BTEST = 6'b010000, SGMAP_DOP_DSKIP = 6'b100000
  } sgmap_dop_t;
  typedef enum logic [7:0] {
    SGMAP_ALU_ADD = 8'h01, SGMAP_ALU_SUB = 8'h02, SGMAP_ALU_AND = 8'h04, SGMAP_ALU_OR  = 8'h08,
    SGMAP_ALU_XOR = 8'h10, SGMAP_ALU_SHL = 8'h20, SGMAP_ALU_SHR = 8'h40, SGMAP_ALU_LD  = 8'h80
  } sgmap_alu_t;
  typedef enum logic [3:0] {
    SGMAP_PC_HOLD = 4'b0001, SGMAP_PC_STEP = 4'b0010, SGMAP_PC_JUMP = 4'b0100, SGMAP_PC_VEC = 4'b1000
  } sgmap_pc_t;

endpackage

// ---- sgmap_pm_model.sv ----
// Program memory stand-in for the mapper bench.
// Assumes a combinational fetch path from the counter outputs.
`timescale 1ns/100ps
module sgmap_pm_model (
  // Program counter
  input  wire logic [6:0] program_counter_high_q,
  input  wire logic [7:0] program_counter_low_q,
  // Fetched byte
  output logic      [7:0] pm_rdata
);
  // Seldom 00 beyond the size, so a missing erased fold shows
  assign pm_rdata = program_counter_low_q ^ {1'b1, program_counter_high_q};
endmodule

// ---- sgmap_ram.sv ----
// Data RAM array, one write port and an asynchronous read port.
// Assumes the address arrives already folded to a RAM slot index.
`timescale 1ns/100ps
module sgmap_ram #(
  parameter int DEPTH = 512
) (
  // Clock
  input  wire logic                     clk_sys,
  // Write
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] idx,
  input  wire logic [7:0]               wr_data,
  // Read
  output logic      [7:0]               rd_data
);

  initial begin
    if (DEPTH < 128) $error("sgmap_ram: DEPTH too small");
  end

  // No reset: contents are undefined at power-up anyway
  logic [7:0] mem [DEPTH];

  assign rd_data = mem[idx];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[idx] <= wr_data;
    end
  end

endmodule

// ---- sgmap_xlate.sv ----
// Data address extension: 8-bit address plus segment to a 16-bit address and RAM slot.
// Assumes the caller resolves pointer and segment registers before any RAM slot.
`timescale 1ns/100ps
module sgmap_xlate #(
  parameter int RAM_SEGS = 4
) (
  // Request
  input  wire logic [7:0]  addr,
  input  wire logic        stack_ref,
  input  wire logic [7:0]  seg_sel,
  // Result
  output logic      [15:0] eff_addr,
  output logic             ram_hit,
  output logic      [8:0]  ram_idx
);
  import sgmap_pkg::*;

  initial begin
    if (RAM_SEGS != 2 && RAM_SEGS != 4) $error("sgmap_xlate: RAM_SEGS must be 2 or 4");
  end

  wire       upper_half = addr[7];
  wire       base_ref   = upper_half | stack_ref;
  wire [7:0] seg_used   = base_ref ? BYTE_ZERO : seg_sel;
  wire       seg_ok     = (seg_used < 8'(RAM_SEGS));
  wire       low_ram    = !upper_half && (addr[6:0] <= LOW_RAM_TOP);
  wire       reg_file   = upper_half && (addr[7:4] == REG_FILE_HI);

  // ***************************************************
  // Extension
  // ***************************************************
  assign eff_addr = upper_half ? {BYTE_ZERO, addr}
                               : {seg_used, 1'b0, addr[6:0]};
  // Segment 0 keeps only 0x00-0x6f; the empty 0x70-0x7f slots hold the register file
  assign ram_hit  = reg_file || (!upper_half && (seg_used == BYTE_ZERO) && low_ram)
                             || (!upper_half && (seg_used != BYTE_ZERO) && seg_ok);
  assign ram_idx  = reg_file ? {5'h07, addr[3:0]} : {seg_used[1:0], addr[6:0]};

endmodule
